// ===== logic/ssam_pkg.sv
// ssam_pkg: constants, field layouts and types of the slave address match front end.
// assumes: one system clock; software registers reached over a plain strobe port.
package ssam_pkg;

  // ==========================================================================
  // register map (index on the plain register port)
  // ==========================================================================
  localparam int REG_ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL_ONE = 4'h0; // control_reg_one
  localparam logic [3:0] OFS_CTRL_TWO = 4'h1; // control_reg_two, slave_control_mask
  localparam logic [3:0] OFS_STATUS = 4'h2; // port_status_reg, read only
  localparam logic [3:0] OFS_DATA_BUF = 4'h3; // data_buffer
  localparam logic [3:0] OFS_SLAVE_ADDR = 4'h4; // slave_address_reg
  localparam logic [3:0] OFS_IRQ_FLAG = 4'h5; // port_interrupt_flag in bit 0

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ==========================================================================
  // field positions and encodings
  // ==========================================================================
  localparam int IRQ_FLAG_BIT = 0;
  localparam logic [3:0] MODE_SLV10_SS = 4'hF; // slave 10-bit, start/stop interrupts
  localparam logic [3:0] MODE_SLV7_SS = 4'hE; // slave 7-bit, start/stop interrupts
  localparam logic [3:0] MODE_FW_MASTER = 4'hB; // firmware master, slave idle
  localparam logic [3:0] MODE_MASTER = 4'h8; // master, slave idle
  localparam logic [3:0] MODE_SLV10 = 4'h7; // slave 10-bit
  localparam logic [3:0] MODE_SLV7 = 4'h6; // slave 7-bit
  localparam logic [4:0] TEN_BIT_TAG = 5'h1E; // first byte pattern of a 10-bit address
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00; // general call address byte
  localparam logic [3:0] BITS_PER_BYTE = 4'h8; // data bits before the acknowledge

  // ==========================================================================
  // register layouts
  // ==========================================================================
  typedef struct packed {
    logic wcol; // write collision, reads zero here
    logic overflow; // receive_overflow_flag
    logic enable; // port_enable
    logic clk_release; // clock_release_ctl
    logic [3:0] mode; // mode_select_field
  } ssam_ctrl_one_s;

  typedef struct packed {
    logic gen_call_en; // general_call_enable
    logic ack_status; // ack_status_flag, unused in slave mode
    logic [4:0] mask; // address_mask_select, bits 5..1
    logic stretch_en; // stretch_enable
  } ssam_ctrl_two_s;

  typedef struct packed {
    logic slew; // reads zero
    logic smbus; // reads zero
    logic data_addr; // last byte was data
    logic stop_seen; // stop detected last
    logic start_seen; // start detected last
    logic read_wr; // read/write bit of last match
    logic upd_addr; // update_address_flag
    logic buf_full; // buffer_full_flag
  } ssam_status_s;

  // receive state, gray along idle-shift-ack-skip
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_ACK = 2'b11,
    ST_SKIP = 2'b10
  } ssam_state_e;

  // which byte of a transfer is being shifted
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_LOW = 2'b01,
    PH_DATA = 2'b11
  } ssam_phase_e;

endpackage : ssam_pkg

// ===== logic/ssam_slave.sv
// ssam_slave: slave address match, acknowledge, buffer and stretch logic.
// assumes: bus pins are open drain with external pull-ups; pins are asynchronous
// to clock_in and are oversampled (bus clock far below clock_in).
`timescale 1ns/1ps
`default_nettype none

// Contract
// - general call interrupts only when enabled
// - upper mask bits make address bits don't-care
// - low mask bit covers bit1, or 1:0
// - stretch enable turns on clock stretching
// - active bus refuses stretch set, buffer writes
// - module works only with port enable
// - four-bit mode field selects operation
// - mode encodings fixed as listed
// - bus lines only pulled low
// - interrupt on exact or masked match
// - match or data: acknowledge and load
// - full or overflow: no ack, flag
// - buffer read clears full; overflow software-cleared
// - wait start, shift 8 rising bits
// - compare bits 7:1 at eighth fall
// - load, full, ack; flag ninth fall
// - 10-bit first byte 11110 xx write
// - high byte sets flag, full, update
// - address write clears update, releases clock
// - low byte sets flags; software restores high
// - repeated-start read high byte: no update
// - masked bits ignored; 10-bit msbs unmasked
// - stretch after data until clock release
module ssam_slave (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // register port
  input wire logic [ssam_pkg::REG_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // event flag
  output logic port_interrupt_flag_out
);
  import ssam_pkg::*;

  // ==========================================================================
  // helpers
  // ==========================================================================
  // masked compare of a received byte against the own address
  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] own,
                                    input logic [4:0] msk, input logic ten);
    logic [7:0] care;
    care = ~{2'b00, msk, ten & msk[0]};
    care[0] = care[0] & ten;
    return ((rx ^ own) & care) == RST_BYTE;
  endfunction : addr_hit

  // mode codes on which the slave engine runs
  function automatic logic is_slave_mode(input logic [3:0] m);
    return (m == MODE_SLV7) || (m == MODE_SLV10) || (m == MODE_SLV7_SS) ||
           (m == MODE_SLV10_SS);
  endfunction : is_slave_mode

  // ==========================================================================
  // storage
  // ==========================================================================
  ssam_ctrl_one_s ctrl_one_reg; // control_reg_one
  ssam_ctrl_two_s ctrl_two_reg; // slave_control_mask
  logic [7:0] data_buffer_reg; // received byte
  logic [7:0] slave_address_reg; // own address
  logic [7:0] shift_reg; // incoming bits
  logic buf_full_reg; // buffer_full_flag
  logic upd_addr_reg; // update_address_flag
  logic irq_flag_reg; // port_interrupt_flag
  logic start_seen_reg; // start seen last
  logic stop_seen_reg; // stop seen last
  logic read_wr_reg; // read bit of last match
  logic data_addr_reg; // last byte was data
  logic hold_reg; // hardware clock stretch
  logic matched10_reg; // full 10-bit address matched
  logic accept_reg; // byte accepted at eighth fall
  logic ack_ok_reg; // byte acknowledged
  logic set_ua_reg; // byte raises update-address
  logic is_read_reg; // address byte asked for a read
  logic [3:0] cnt_reg; // bits shifted
  ssam_state_e state_reg;
  ssam_state_e state_next;
  ssam_phase_e phase_reg;
  ssam_phase_e phase_next;
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg; // scl synchroniser and history
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg; // sda synchroniser and history
  logic sda_oe_reg; // acknowledge drive
  logic scl_oe_reg; // stretch drive
  logic [7:0] rdata_reg; // read data

  // ==========================================================================
  // pin synchronisers and bus events
  // ==========================================================================
  // two flops, then a third for edge history
  always_ff @(posedge clock_in) begin
    scl_s1_reg <= scl_in;
    scl_s2_reg <= scl_s1_reg;
    scl_s3_reg <= scl_s2_reg;
    sda_s1_reg <= sda_in;
    sda_s2_reg <= sda_s1_reg;
    sda_s3_reg <= sda_s2_reg;
  end

  wire scl_rise = scl_s2_reg & ~scl_s3_reg; // clock rising
  wire scl_fall = ~scl_s2_reg & scl_s3_reg; // clock falling
  // start: data falls with clock high; stop: data rises with clock high
  wire start_det = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
  wire stop_det = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;

  // ==========================================================================
  // mode decode
  // ==========================================================================
  // enable gate
  wire slave_on = ctrl_one_reg.enable & is_slave_mode(ctrl_one_reg.mode);
  wire ten_bit = ctrl_one_reg.mode[0]; // 10-bit codes have bit 0 set
  wire ss_irq = ctrl_one_reg.mode[3]; // start/stop interrupt variants
  wire active = (state_reg != ST_IDLE); // module busy on the bus

  // ==========================================================================
  // address decision at the eighth falling edge
  // ==========================================================================
  // compare at eighth fall
  wire dec8 = (state_reg == ST_SHIFT) & scl_fall & (cnt_reg == BITS_PER_BYTE);
  wire hit7 = addr_hit(shift_reg, slave_address_reg, ctrl_two_reg.mask, 1'b0);
  wire hit_low = addr_hit(shift_reg, slave_address_reg, ctrl_two_reg.mask, 1'b1);
  wire hit_high = (shift_reg[7:3] == TEN_BIT_TAG) &
                  (shift_reg[2:1] == slave_address_reg[2:1]);
  wire gen_call = ctrl_two_reg.gen_call_en & (shift_reg == GEN_CALL_ADDR);
  wire rx_read = shift_reg[0]; // read/write bit of an address byte
  wire addr_ok7 = hit7 | gen_call;
  wire addr_ok10 = hit_high & (~rx_read | matched10_reg);
  wire accept = (phase_reg == PH_DATA) | ((phase_reg == PH_LOW) & hit_low) |
                ((phase_reg == PH_ADDR) & (ten_bit ? addr_ok10 : addr_ok7));
  wire ack_ok = accept & ~buf_full_reg & ~ctrl_one_reg.overflow;
  wire set_ua = ten_bit & (((phase_reg == PH_ADDR) & ~rx_read) | (phase_reg == PH_LOW));
  wire is_read = (phase_reg == PH_ADDR) & rx_read;
  wire load_buf = dec8 & ack_ok; // buffer load
  wire ovf_set = dec8 & accept & ~ack_ok & (phase_reg == PH_DATA);
  wire nine_fall = (state_reg == ST_ACK) & scl_fall; // end of acknowledge
  wire rx_stretch = nine_fall & (phase_reg == PH_DATA) & ctrl_two_reg.stretch_en &
                    (buf_full_reg | load_buf);
  wire tx_stretch = nine_fall & is_read_reg & ack_ok_reg; // read needs data
  wire stretch_set = rx_stretch | tx_stretch;

  // ==========================================================================
  // receive sequencer
  // ==========================================================================
  // wait start, shift eight
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    if (!slave_on) begin
      state_next = ST_IDLE;
      phase_next = PH_ADDR;
    end else if (start_det) begin
      state_next = ST_SHIFT;
      phase_next = PH_ADDR;
    end else if (stop_det) begin
      state_next = ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: state_next = ST_IDLE;
        ST_SHIFT: begin
          if (dec8) begin
            state_next = accept ? ST_ACK : ST_SKIP;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            // reads and refused addresses stop receiving
            state_next = (is_read_reg | (~ack_ok_reg & phase_reg != PH_DATA)) ?
                         ST_SKIP : ST_SHIFT;
            phase_next = (phase_reg == PH_ADDR && ten_bit && !matched10_reg) ?
                         PH_LOW : PH_DATA;
          end
        end
        ST_SKIP: state_next = ST_SKIP;
      endcase
    end
  end

  // state, bit counter and shifter
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_ADDR;
      cnt_reg <= 4'h0;
      shift_reg <= RST_BYTE;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      if (start_det || nine_fall) begin
        cnt_reg <= 4'h0;
      end else if (state_reg == ST_SHIFT && scl_rise && cnt_reg != BITS_PER_BYTE) begin
        cnt_reg <= cnt_reg + 4'h1;
        shift_reg <= {shift_reg[6:0], sda_s2_reg};
      end
    end
  end

  // per-byte decision held through the acknowledge clock
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      accept_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      set_ua_reg <= 1'b0;
      is_read_reg <= 1'b0;
      matched10_reg <= 1'b0;
    end else begin
      if (dec8) begin
        accept_reg <= accept;
        ack_ok_reg <= ack_ok;
        set_ua_reg <= set_ua;
        is_read_reg <= is_read;
      end
      if (!slave_on || stop_det) begin
        matched10_reg <= 1'b0;
      end else if (dec8 && phase_reg == PH_LOW && ack_ok) begin
        matched10_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // status flags
  // ==========================================================================
  wire wr_ctrl_one = reg_wr_in & (reg_addr_in == OFS_CTRL_ONE);
  wire wr_ctrl_two = reg_wr_in & (reg_addr_in == OFS_CTRL_TWO);
  wire wr_data = reg_wr_in & (reg_addr_in == OFS_DATA_BUF);
  wire wr_saddr = reg_wr_in & (reg_addr_in == OFS_SLAVE_ADDR);
  wire wr_irq = reg_wr_in & (reg_addr_in == OFS_IRQ_FLAG);
  wire rd_data = reg_rd_in & (reg_addr_in == OFS_DATA_BUF);
  wire ss_event = slave_on & ss_irq & (start_det | stop_det);
  wire irq_set = (nine_fall & accept_reg) | ss_event;
  wire ua_set = nine_fall & set_ua_reg & ack_ok_reg;
  ssam_ctrl_one_s w1;
  ssam_ctrl_two_s w2;
  assign w1 = reg_wdata_in;
  assign w2 = reg_wdata_in;

  // flags: hardware set wins over a clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      buf_full_reg <= 1'b0;
      upd_addr_reg <= 1'b0;
      irq_flag_reg <= 1'b0;
      read_wr_reg <= 1'b0;
      data_addr_reg <= 1'b0;
    end else begin
      buf_full_reg <= load_buf | (buf_full_reg & ~rd_data);
      upd_addr_reg <= ua_set | (upd_addr_reg & ~wr_saddr);
      irq_flag_reg <= irq_set | (irq_flag_reg & ~(wr_irq & ~reg_wdata_in[IRQ_FLAG_BIT]));
      if (load_buf) begin
        data_addr_reg <= (phase_reg == PH_DATA);
        if (phase_reg == PH_ADDR) begin
          read_wr_reg <= rx_read;
        end
      end
    end
  end

  // start and stop seen, cleared while disabled
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end else if (!ctrl_one_reg.enable) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end else if (start_det || stop_det) begin
      start_seen_reg <= start_det;
      stop_seen_reg <= stop_det;
    end
  end

  // ==========================================================================
  // software registers
  // ==========================================================================
  // control registers and buffers
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctrl_one_reg <= RST_CTRL_ONE;
      ctrl_two_reg <= RST_CTRL_TWO;
      data_buffer_reg <= RST_BYTE;
      slave_address_reg <= RST_BYTE;
      hold_reg <= 1'b0;
    end else begin
      if (wr_ctrl_one) begin
        ctrl_one_reg <= w1;
        ctrl_one_reg.wcol <= 1'b0;
      end
      // overflow set by hardware, cleared by software only
      if (ovf_set) begin
        ctrl_one_reg.overflow <= 1'b1;
      end
      // hardware stretch clears clock release
      if (stretch_set) begin
        ctrl_one_reg.clk_release <= 1'b0;
        hold_reg <= 1'b1;
      end else if (wr_ctrl_one && w1.clk_release) begin
        hold_reg <= 1'b0;
      end
      if (wr_ctrl_two) begin
        ctrl_two_reg <= {w2.gen_call_en, 1'b0, w2.mask,
                         w2.stretch_en & (~active | ctrl_two_reg.stretch_en)};
      end
      if (load_buf) begin
        data_buffer_reg <= shift_reg;
      end else if (wr_data && !active) begin
        data_buffer_reg <= reg_wdata_in;
      end
      if (wr_saddr) begin
        slave_address_reg <= reg_wdata_in;
      end
    end
  end

  // read mux and one-cycle read data
  ssam_status_s status;
  assign status = {2'b00, data_addr_reg, stop_seen_reg, start_seen_reg, read_wr_reg,
                   upd_addr_reg, buf_full_reg};
  wire [7:0] rd_mux = (reg_addr_in == OFS_CTRL_ONE) ? ctrl_one_reg :
                      (reg_addr_in == OFS_CTRL_TWO) ? ctrl_two_reg :
                      (reg_addr_in == OFS_STATUS) ? status :
                      (reg_addr_in == OFS_DATA_BUF) ? data_buffer_reg :
                      (reg_addr_in == OFS_SLAVE_ADDR) ? slave_address_reg :
                      (reg_addr_in == OFS_IRQ_FLAG) ? {7'h00, irq_flag_reg} : RST_BYTE;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rdata_reg <= RST_BYTE;
    end else begin
      rdata_reg <= reg_rd_in ? rd_mux : RST_BYTE;
    end
  end

  // ==========================================================================
  // pin drivers
  // ==========================================================================
  // open drain, low only
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
    end else begin
      if (!slave_on || start_det || stop_det || nine_fall) begin
        sda_oe_reg <= 1'b0;
      end else if (load_buf) begin
        sda_oe_reg <= 1'b1;
      end
      scl_oe_reg <= slave_on & (hold_reg | stretch_set | (upd_addr_reg & ~wr_saddr) |
                                ua_set);
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = scl_oe_reg;
  assign sda_oe_out = sda_oe_reg;
  assign reg_rdata_out = rdata_reg;
  assign port_interrupt_flag_out = irq_flag_reg;

  // ==========================================================================
  // assertions
  // ==========================================================================
  gen_call_ack_a: assert property (@(posedge clock_in) disable iff (reset_in)
    dec8 && phase_reg == PH_ADDR && !ten_bit && shift_reg == 8'h00 &&
    ctrl_two_reg.gen_call_en && !buf_full_reg && !ctrl_one_reg.overflow
    |=> sda_oe_reg && state_reg == ST_ACK)
    else $error("general call not acknowledged");

  full_nack_a: assert property (@(posedge clock_in) disable iff (reset_in)
    dec8 && (buf_full_reg || ctrl_one_reg.overflow) |=> !sda_oe_reg && $stable(data_buffer_reg))
    else $error("acknowledge given while buffer full");

  read_clears_a: assert property (@(posedge clock_in) disable iff (reset_in)
    rd_data && !load_buf |=> !buf_full_reg)
    else $error("buffer read did not clear full flag");

  ninth_flag_a: assert property (@(posedge clock_in) disable iff (reset_in)
    nine_fall && accept_reg |=> irq_flag_reg && !sda_oe_reg)
    else $error("flag not set at end of acknowledge");

  busy_write_a: assert property (@(posedge clock_in) disable iff (reset_in)
    wr_data && active && !load_buf |=> $stable(data_buffer_reg))
    else $error("buffer written while active");

  disabled_quiet_a: assert property (@(posedge clock_in) disable iff (reset_in)
    !slave_on |=> !sda_oe_reg && !scl_oe_reg)
    else $error("pins driven while disabled");

  addr_release_a: assert property (@(posedge clock_in) disable iff (reset_in)
    wr_saddr && !ua_set |=> !upd_addr_reg)
    else $error("address write did not clear update flag");

  data_stretch_a: assert property (@(posedge clock_in) disable iff (reset_in)
    rx_stretch && slave_on ##1 slave_on |-> hold_reg && scl_oe_reg)
    else $error("clock not held after data byte");

  exact_match_a: assert property (@(posedge clock_in) disable iff (reset_in)
    dec8 && phase_reg == PH_ADDR && !ten_bit && shift_reg[7:1] == slave_address_reg[7:1] &&
    !buf_full_reg && !ctrl_one_reg.overflow |=> buf_full_reg ##0 data_buffer_reg == $past(shift_reg))
    else $error("exact match not loaded");

endmodule : ssam_slave

`default_nettype wire

// ===== verif/ssam_bus_master.sv
// ssam_bus_master: behavioural bus master on the two open-drain lines.
// assumes: pull-ups on both lines; the slave drives only its pull-low enables.
`timescale 1ns/1ps
`default_nettype none
module ssam_bus_master (
  // slave pull-low enables
  input wire logic scl_oe_in,
  input wire logic sda_oe_in,
  // resolved line levels
  output logic scl_out,
  output logic sda_out
);
  logic scl_pull = 1'b0; // master pulls clock low
  logic sda_pull = 1'b0; // master pulls data low
  // wired-and: a released line floats up
  assign scl_out = ~(scl_pull | scl_oe_in);
  assign sda_out = ~(sda_pull | sda_oe_in);
  // data falls while clock is high
  // line changes by non-blocking assignment, so edges never race the sampling clock
  task automatic start_cond();
    sda_pull <= 1'b1;
    #80;
    scl_pull <= 1'b1;
    #40;
  endtask : start_cond
  // eight bits msb first, then a released ninth bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_pull <= (i > 0) ? ~b[i-1] : 1'b0;
      #40;
      scl_pull <= 1'b0;
      // a stretched clock holds us here
      wait (scl_out);
      #80;
      ack = ~sda_out;
      scl_pull <= 1'b1;
      #40;
    end
  endtask : send_byte
  // data rises while clock is high; clock then idles high
  task automatic stop_cond();
    sda_pull <= 1'b1;
    #40;
    scl_pull <= 1'b0;
    #40;
    sda_pull <= 1'b0;
    #80;
  endtask : stop_cond
endmodule : ssam_bus_master
`default_nettype wire

// ===== verif/tb_i2c_slave_address_match.sv
// tb_i2c_slave_address_match: self-checking bench of the slave address match.
// assumes: ssam_pkg compiled first; bus master model drives the lines.
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_slave_address_match;
  import ssam_pkg::*;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [REG_ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic scl_line, sda_line, scl_oe, sda_oe, irq;
  logic scl_do, sda_do; // open-drain output levels, always low
  int errors = 0;
  int tests_run = 0;
  always #5 clock_in = ~clock_in;
  ssam_slave dut (.clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .scl_in(scl_line), .scl_out(scl_do), .scl_oe_out(scl_oe),
    .sda_in(sda_line), .sda_out(sda_do), .sda_oe_out(sda_oe), .port_interrupt_flag_out(irq));
  ssam_bus_master m (.scl_oe_in(scl_oe), .sda_oe_in(sda_oe), .scl_out(scl_line),
    .sda_out(sda_line));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      errors++;
    end
  endtask : check
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock_in);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock_in);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  // one address frame, then buffer and flag bookkeeping
  task automatic txn(input logic [7:0] b, input logic exp_ack);
    logic ack;
    logic [7:0] d;
    m.start_cond();
    m.send_byte(b, ack);
    m.stop_cond();
    repeat (8) @(posedge clock_in);
    check("ack", {7'h00, ack}, {7'h00, exp_ack});
    check("irq", {7'h00, irq}, {7'h00, exp_ack});
    reg_read(OFS_STATUS, d);
    check("full", d & 8'h01, {7'h00, exp_ack});
    reg_read(OFS_DATA_BUF, d);
    if (exp_ack) check("buffer", d, b);
    reg_read(OFS_STATUS, d);
    check("full_clr", d & 8'h01, 8'h00);
    reg_write(OFS_IRQ_FLAG, 8'h00);
  endtask : txn
  task automatic scn_reset();
    logic [3:0] ofs[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hF};
    logic [7:0] d;
    foreach (ofs[i]) begin
      reg_read(ofs[i], d);
      check("reset", d, 8'h00);
    end
    check("od_low", {6'h00, scl_do, sda_do}, 8'h00);
  endtask : scn_reset
  // mask bits 3..1 set: eight addresses around A0 answer
  task automatic scn_mask();
    logic [7:0] ad[4] = '{8'hA6, 8'hAE, 8'hB0, 8'h20};
    logic ex[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    reg_write(OFS_SLAVE_ADDR, 8'hA0);
    reg_write(OFS_CTRL_TWO, 8'h0E);
    reg_write(OFS_CTRL_ONE, 8'h26);
    foreach (ad[i]) txn(ad[i], ex[i]);
  endtask : scn_mask
  // unread address byte makes the data byte overflow
  task automatic scn_overflow();
    logic ack;
    logic [7:0] d;
    m.start_cond();
    m.send_byte(8'hA0, ack);
    // clear the address flag so the refused byte must raise it again
    reg_write(OFS_IRQ_FLAG, 8'h00);
    m.send_byte(8'h55, ack);
    check("ovf_ack", {7'h00, ack}, 8'h00);
    reg_write(OFS_DATA_BUF, 8'h77);
    reg_write(OFS_CTRL_TWO, 8'h0F);
    reg_read(OFS_CTRL_TWO, d);
    check("sen_busy", d, 8'h0E);
    m.stop_cond();
    repeat (8) @(posedge clock_in);
    check("ovf_irq", {7'h00, irq}, 8'h01);
    reg_read(OFS_DATA_BUF, d);
    check("ovf_buf", d, 8'hA0);
    reg_read(OFS_CTRL_ONE, d);
    check("ovf_flag", d, 8'h66);
    reg_write(OFS_CTRL_ONE, 8'h26);
    reg_write(OFS_IRQ_FLAG, 8'h00);
  endtask : scn_overflow
  // general call ignored, then answered
  task automatic scn_gen_call();
    for (int g = 0; g < 2; g++) begin
      reg_write(OFS_CTRL_TWO, {g[0], 7'h0E});
      txn(8'h00, g[0]);
    end
  endtask : scn_gen_call
  // disabled, master and slave modes
  task automatic scn_modes();
    logic [7:0] md[5] = '{8'h06, 8'h28, 8'h2B, 8'h2E, 8'h27};
    logic ex[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    foreach (md[i]) begin
      reg_write(OFS_CTRL_ONE, md[i]);
      txn(8'hA0, ex[i]);
    end
  endtask : scn_modes
  // 10-bit write: high byte, low byte under mask 1:0, then one stretched data byte
  task automatic scn_ten();
    logic ack;
    logic [7:0] d;
    reg_write(OFS_SLAVE_ADDR, 8'hF2);
    reg_write(OFS_CTRL_TWO, 8'h03);
    reg_write(OFS_CTRL_ONE, 8'h37);
    m.start_cond();
    m.send_byte(8'hF2, ack);
    repeat (4) @(posedge clock_in);
    check("hi_ack", {5'h00, ack, irq, scl_oe}, 8'h07);
    reg_read(OFS_STATUS, d);
    check("hi_stat", d, 8'h0B);
    reg_write(OFS_SLAVE_ADDR, 8'hA4);
    repeat (2) @(posedge clock_in);
    check("hi_rel", {7'h00, scl_oe}, 8'h00);
    reg_read(OFS_DATA_BUF, d);
    check("hi_buf", d, 8'hF2);
    reg_write(OFS_IRQ_FLAG, 8'h00);
    m.send_byte(8'hA7, ack);
    repeat (4) @(posedge clock_in);
    check("lo_ack", {5'h00, ack, irq, scl_oe}, 8'h07);
    reg_read(OFS_STATUS, d);
    check("lo_stat", d, 8'h0B);
    reg_write(OFS_SLAVE_ADDR, 8'hF2);
    reg_read(OFS_DATA_BUF, d);
    check("lo_buf", d, 8'hA7);
    reg_write(OFS_IRQ_FLAG, 8'h00);
    m.send_byte(8'h3C, ack);
    repeat (4) @(posedge clock_in);
    check("dat_hold", {6'h00, ack, scl_oe}, 8'h03);
    reg_read(OFS_CTRL_ONE, d);
    check("ckp_clr", d, 8'h27);
    reg_read(OFS_DATA_BUF, d);
    check("dat_buf", d, 8'h3C);
    reg_write(OFS_CTRL_ONE, 8'h37);
    repeat (2) @(posedge clock_in);
    check("dat_rel", {7'h00, scl_oe}, 8'h00);
    m.stop_cond();
  endtask : scn_ten
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(posedge clock_in);
    reset_in <= 1'b0;
    scn_reset();
    scn_mask();
    scn_overflow();
    scn_gen_call();
    scn_modes();
    scn_ten();
    tally_and_finish();
  end
  initial begin
    #500us;
    errors++;
    tally_and_finish();
  end
endmodule : tb_i2c_slave_address_match
`default_nettype wire
